/* File: inc/gated_counter_consts.svh */
// Constants of the gated 16-bit counter: register byte offsets, field positions, reset values.
// Assumes inclusion by bare name from design and bench files.
`ifndef GATED_COUNTER_CONSTS_SVH
`define GATED_COUNTER_CONSTS_SVH

`define CTR_OFS_CONTROL 12'h000
`define CTR_OFS_GATE_CONTROL 12'h004
`define CTR_OFS_COUNT_LOW 12'h008
`define CTR_OFS_COUNT_HIGH 12'h00c
`define CTR_OFS_INT_STATUS 12'h010
`define CTR_OFS_INT_MASK 12'h014

`define CTR_BIT_COUNT_ON 0
`define CTR_BIT_CLOCK_EXT 1
`define CTR_POS_PRESCALE 2
`define CTR_BIT_SYNC_BYPASS 4
`define CTR_BIT_LP_OSC_ENABLE 5
`define CTR_CONTROL_WIDTH 6
`define CTR_CONTROL_RESET 6'h00

`define CTR_BIT_GATE_ENABLE 0
`define CTR_BIT_GATE_POLARITY 1
`define CTR_POS_GATE_SOURCE 2
`define CTR_BIT_GATE_LEVEL 4
`define CTR_GATE_WIDTH 4
`define CTR_GATE_RESET 4'h0

`define CTR_BIT_OVERFLOW 0
`define CTR_COUNT_RESET 16'h0000
`define CTR_COUNT_MAX 16'hffff
`define CTR_PRESCALE_RESET 3'h0
`define CTR_GATE_SOURCES 4

`endif

/* File: inc/gated_counter_pkg.sv */
// Types used by the gated 16-bit counter; the bench does not use them.
// Assumes nothing of its surroundings.
package gated_counter_pkg;

  typedef logic [15:0] count_type;
  typedef logic [1:0] prescale_select_type;
  typedef logic [1:0] gate_source_type;
  typedef enum logic {clock_internal, clock_external} clock_source_type;

endpackage

/* File: rtl/gated_counter.sv */
// Gated 16-bit up-counter with 1/2/4/8 prescaler, low-power oscillator control and APB registers.
// Assumes one clock pclk; all pin inputs pass level_sync before any logic reads them.
//
// Functional notes
// - Prescale ratio 1, 2, 4 or 8 chosen by the two-bit prescale_select field.
// - Prescale counter is hidden from software and cleared by any count byte write.
// - Low-power oscillator runs only while lp_osc_enable is set.
// - Enabled oscillator keeps running during sleep.
// - With sync_bypass set the external clock skips the extra synchronising stage.
// - Asynchronous mode with external clock keeps counting in sleep; overflow can wake.
// - Mode switches may lose one increment or add one; both are accepted.
// - Count byte reads return a valid value while counting from the external clock.
// - Counter counts freely or under control of the gate circuitry.
// - gate_enable turns gating on; gate_polarity picks the active gate level.
// - Gated counter increments only when gate level equals gate_polarity.
// - While the gate disables counting the count holds its value.
// - Gate signal is chosen from four sources by the gate source select field.
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`include "gated_counter_consts.svh"

module gated_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep,
  input wire logic ext_clock_pin,
  input wire logic crystal_in_pin,
  output logic crystal_out_pin,
  output logic osc_running,
  input wire logic [3:0] gate_source_pins,
  output logic irq
);

  logic [`CTR_CONTROL_WIDTH-1:0] counter_control_reg;
  logic [`CTR_GATE_WIDTH-1:0] gate_control_reg;
  gated_counter_pkg::count_type count_reg;
  gated_counter_pkg::count_type count_next;
  logic [2:0] prescale_reg;
  logic [2:0] prescale_next;
  logic overflow_flag;
  logic overflow_mask_reg;
  logic ext_stage_reg;
  logic clk_level_prev_reg;
  logic osc_drive_reg;

  logic ext_clock_sync;
  logic crystal_sync;
  logic [`CTR_GATE_SOURCES-1:0] gate_sync;

  // Every pin passes two flip-flops before it is used.
  level_sync ext_clock_sync_u (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(ext_clock_pin),
    .sync_out(ext_clock_sync)
  );

  level_sync crystal_sync_u (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(crystal_in_pin),
    .sync_out(crystal_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `CTR_GATE_SOURCES; gi = gi + 1) begin : gate_sync_g
      level_sync gate_sync_u (
        .clk(pclk),
        .rst_n(presetn),
        .async_in(gate_source_pins[gi]),
        .sync_out(gate_sync[gi])
      );
    end
  endgenerate

  // Configuration fields.
  wire count_on = counter_control_reg[`CTR_BIT_COUNT_ON];
  wire gated_counter_pkg::clock_source_type clock_source =
    gated_counter_pkg::clock_source_type'(counter_control_reg[`CTR_BIT_CLOCK_EXT]);
  wire gated_counter_pkg::prescale_select_type prescale_select =
    counter_control_reg[`CTR_POS_PRESCALE +: 2];
  wire sync_bypass = counter_control_reg[`CTR_BIT_SYNC_BYPASS];
  wire lp_osc_enable = counter_control_reg[`CTR_BIT_LP_OSC_ENABLE];
  wire gate_enable = gate_control_reg[`CTR_BIT_GATE_ENABLE];
  wire gate_polarity = gate_control_reg[`CTR_BIT_GATE_POLARITY];
  wire gated_counter_pkg::gate_source_type gate_source_sel =
    gate_control_reg[`CTR_POS_GATE_SOURCE +: 2];

  // The crystal replaces the external clock pin while the oscillator is enabled.
  wire ext_clock_level = lp_osc_enable ? crystal_sync : ext_clock_sync;

  // Sync mode adds one more stage; that stage is why a switch can drop or add one edge.
  wire selected_level = sync_bypass ? ext_clock_level : ext_stage_reg;
  wire ext_edge = selected_level & ~clk_level_prev_reg;

  // Internal clocking stops in sleep; only bypassed external counting survives it.
  wire sleep_ok = ~sleep |
    (sync_bypass & (clock_source == gated_counter_pkg::clock_external));
  wire source_tick = (clock_source == gated_counter_pkg::clock_external) ? ext_edge : 1'b1;

  wire gate_signal = gate_sync[gate_source_sel];
  wire gate_ok = ~gate_enable | (gate_signal == gate_polarity);
  wire count_allowed = count_on & gate_ok & sleep_ok;
  wire pre_tick = count_allowed & source_tick;

  wire [2:0] prescale_mask = (prescale_select == 2'h0) ? 3'h0 :
                             (prescale_select == 2'h1) ? 3'h1 :
                             (prescale_select == 2'h2) ? 3'h3 : 3'h7;
  wire prescale_done = ((prescale_reg & prescale_mask) == prescale_mask);
  wire count_tick = pre_tick & prescale_done;
  wire wrap = count_tick & (count_reg == `CTR_COUNT_MAX);

  // APB decode; the answer comes one cycle into the access phase.
  wire access = psel & penable;
  wire complete = access & pready;
  wire wr_done = complete & pwrite;
  wire hit_control = (paddr == `CTR_OFS_CONTROL);
  wire hit_gate = (paddr == `CTR_OFS_GATE_CONTROL);
  wire hit_low = (paddr == `CTR_OFS_COUNT_LOW);
  wire hit_high = (paddr == `CTR_OFS_COUNT_HIGH);
  wire hit_status = (paddr == `CTR_OFS_INT_STATUS);
  wire hit_mask = (paddr == `CTR_OFS_INT_MASK);
  wire hit_any = hit_control | hit_gate | hit_low | hit_high | hit_status | hit_mask;
  wire wr_low = wr_done & hit_low;
  wire wr_high = wr_done & hit_high;
  wire clear_overflow = wr_done & hit_status & pwdata[`CTR_BIT_OVERFLOW];
  wire wr_control = wr_done & hit_control;
  wire wr_gate = wr_done & hit_gate;
  wire wr_mask = wr_done & hit_mask;
  // Read data is taken in the wait cycle so that it stands while pready is high.
  wire rd_capture = access & ~pready & ~pwrite;

  // The count is sampled on pclk, so both bytes always read a settled value.
  wire [31:0] read_value =
    hit_control ? {26'h0000000, counter_control_reg} :
    hit_gate ? {27'h0000000, gate_signal, gate_control_reg} :
    hit_low ? {24'h000000, count_reg[7:0]} :
    hit_high ? {24'h000000, count_reg[15:8]} :
    hit_status ? {31'h00000000, overflow_flag} :
    hit_mask ? {31'h00000000, overflow_mask_reg} : 32'h00000000;

  // A byte write wins over a simultaneous increment; software is asked to stop first.
  always_comb begin
    count_next = count_reg;
    if (count_tick) begin
      count_next = count_reg + 16'h0001;
    end
    if (wr_low) begin
      count_next = {count_reg[15:8], pwdata[7:0]};
    end
    if (wr_high) begin
      count_next = {pwdata[7:0], count_reg[7:0]};
    end
  end

  always_comb begin
    prescale_next = prescale_reg;
    if (pre_tick) begin
      prescale_next = prescale_done ? `CTR_PRESCALE_RESET : prescale_reg + 3'h1;
    end
    if (wr_low | wr_high) begin
      prescale_next = `CTR_PRESCALE_RESET;
    end
  end

  // Each register has its own short process so that its reset value is plain to see.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access & ~pready & ~hit_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_capture) begin
      prdata <= read_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_control_reg <= `CTR_CONTROL_RESET;
    end else if (wr_control) begin
      counter_control_reg <= pwdata[`CTR_CONTROL_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_control_reg <= `CTR_GATE_RESET;
    end else if (wr_gate) begin
      gate_control_reg <= pwdata[`CTR_GATE_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_mask_reg <= 1'b0;
    end else if (wr_mask) begin
      overflow_mask_reg <= pwdata[`CTR_BIT_OVERFLOW];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= `CTR_COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_reg <= `CTR_PRESCALE_RESET;
    end else begin
      prescale_reg <= prescale_next;
    end
  end

  // The extra stage delays the external level by one clock in synchronous mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_stage_reg <= 1'b0;
    end else begin
      ext_stage_reg <= ext_clock_level;
    end
  end

  // Reset low matches the idle level of the clock pins, so no false edge follows reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_level_prev_reg <= 1'b0;
    end else begin
      clk_level_prev_reg <= selected_level;
    end
  end

  // A new overflow in the clearing cycle keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (clear_overflow) begin
      overflow_flag <= 1'b0;
    end
  end

  // Interrupt stays live in sleep so a bypassed external count can wake the core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= overflow_flag & overflow_mask_reg;
    end
  end

  // The amplifier output follows the crystal only while enabled; sleep does not stop it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_drive_reg <= 1'b0;
    end else begin
      osc_drive_reg <= lp_osc_enable & ~crystal_sync;
    end
  end

  // Gating with the enable stops the drive in the same cycle in which osc_running falls.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_out_pin <= 1'b0;
    end else begin
      crystal_out_pin <= osc_drive_reg & lp_osc_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_running <= 1'b0;
    end else begin
      osc_running <= lp_osc_enable;
    end
  end

endmodule // gated_counter

/* File: rtl/level_sync.sv */
// Two-flip-flop synchroniser for one level coming from a pin.
// Assumes the input is asynchronous to clk; only the second stage is visible.
`timescale 1ns/100ps

module level_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  logic first_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      first_reg <= async_in;
      sync_out <= first_reg;
    end
  end

endmodule // level_sync

/* File: tb/crystal_model.sv */
// Behavioural external crystal on the low-power oscillator pins.
// Assumes the enable follows the oscillator enable; faster than a real crystal to keep runs short.
`timescale 1ns/100ps
module crystal_model #(parameter int HALF_NS = 40) (
  input wire logic enable,
  output logic xtal
);
  initial begin
    xtal = 1'b0;
    #1.3;
    forever begin
      #HALF_NS;
      xtal = (enable === 1'b1) ? ~xtal : 1'b0;
    end
  end
endmodule // crystal_model

/* File: tb/gated_counter_sva.sv */
// Concurrent checks on the ports of the gated counter.
// Assumes the single pclk domain and the constants header.
`timescale 1ns/100ps
`include "gated_counter_consts.svh"
module gated_counter_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep,
  input wire logic ext_clock_pin,
  input wire logic crystal_in_pin,
  input wire logic crystal_out_pin,
  input wire logic osc_running,
  input wire logic [3:0] gate_source_pins,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  property p_wait_state;
    $rose(penable) && psel |-> s_wait ##1 s_done;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_map;
    pready |-> pslverr == !(paddr inside {`CTR_OFS_CONTROL, `CTR_OFS_GATE_CONTROL,
      `CTR_OFS_COUNT_LOW, `CTR_OFS_COUNT_HIGH, `CTR_OFS_INT_STATUS, `CTR_OFS_INT_MASK});
  endproperty
  property p_err_zero;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  property p_byte_read;
    pready && !pwrite && (paddr == `CTR_OFS_COUNT_LOW || paddr == `CTR_OFS_COUNT_HIGH)
      |-> prdata[31:8] == 24'h0;
  endproperty
  property p_osc_off;
    !osc_running |-> !crystal_out_pin;
  endproperty
  property p_osc_sleep;
    osc_running && sleep && !psel |=> osc_running;
  endproperty
  property p_irq_mask;
    pready && pwrite && paddr == `CTR_OFS_INT_MASK && !pwdata[0] |=> ##1 !irq;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("apb answer not after one wait");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_err_map: assert property (p_err_map) else $error("pslverr does not match address map");
  a_err_zero: assert property (p_err_zero) else $error("refused read data not zero");
  a_byte_read: assert property (p_byte_read) else $error("count byte upper bits set");
  a_osc_off: assert property (p_osc_off) else $error("crystal drive while disabled");
  a_osc_sleep: assert property (p_osc_sleep) else $error("oscillator stopped in sleep");
  a_irq_mask: assert property (p_irq_mask) else $error("irq high while masked");
endmodule // gated_counter_sva

bind gated_counter gated_counter_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .sleep, .ext_clock_pin, .crystal_in_pin,
  .crystal_out_pin, .osc_running, .gate_source_pins, .irq);

/* File: tb/gated_counter_tb_top.sv */
// Self-checking bench for the gated counter, driving APB and the pins.
// Assumes the APB slave answers with pready; every wait is bounded.
`timescale 1ns/100ps
`include "gated_counter_consts.svh"
module gated_counter_tb_top;
  logic pclk, presetn, psel, penable, pwrite, sleep, ext_clock_pin, err;
  logic pready, pslverr, crystal_in_pin, crystal_out_pin, osc_running, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] gate_source_pins;
  logic ext_run;
  int ext_div = 0;
  int miscompares = 0;
  int check_count = 0;
  int n;
  gated_counter DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sleep, .ext_clock_pin, .crystal_in_pin, .crystal_out_pin,
    .osc_running, .gate_source_pins, .irq);
  crystal_model #(.HALF_NS(40)) xtal (.enable(osc_running), .xtal(crystal_in_pin));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // External count clock: ten pclk periods, half high, only while ext_run is set.
  always @(posedge pclk) begin
    ext_div <= (ext_div + 1) % 10;
    ext_clock_pin <= ext_run && ext_div < 5;
  end
  task end_of_test;
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      miscompares++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), e, rd);
  endtask
  task restart(input logic [31:0] ctl);
    xfer(1'b1, `CTR_OFS_CONTROL, 32'h0);
    xfer(1'b1, `CTR_OFS_COUNT_LOW, 32'h0);
    xfer(1'b1, `CTR_OFS_COUNT_HIGH, 32'h0);
    xfer(1'b1, `CTR_OFS_CONTROL, ctl);
    // Let the oscillator and synchronisers settle so each span sees steady counting.
    repeat (40) @(posedge pclk);
  endtask
  task span(input int k, input logic [7:0] e);
    logic [7:0] s;
    xfer(1'b0, `CTR_OFS_COUNT_LOW, 32'h0);
    s = rd[7:0];
    repeat (k - 4) @(posedge pclk);
    xfer(1'b0, `CTR_OFS_COUNT_LOW, 32'h0);
    chk("count span", {24'h0, e}, {24'h0, rd[7:0] - s});
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep, ext_run} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    gate_source_pins = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`CTR_OFS_CONTROL, `CTR_CONTROL_RESET);
    rchk(`CTR_OFS_GATE_CONTROL, `CTR_GATE_RESET);
    xfer(1'b1, 12'h020, 32'h1);
    chk("unmapped error", 32'h1, err);
    rchk(12'h020, 32'h0);
    chk("unmapped read error", 32'h1, err);
    for (int p = 0; p < 4; p++) begin
      restart(1 | (p << 2));
      span(64, 8'(64 >> p));
    end
    // Gating is measured at a prescale ratio of one.
    restart(32'h1);
    for (int i = 0; i < 16; i++) begin
      xfer(1'b1, `CTR_OFS_GATE_CONTROL, {i[3:2], i[1], 1'b1});
      gate_source_pins <= {4{~i[0]}} ^ (4'h1 << i[3:2]);
      repeat (4) @(posedge pclk);
      rchk(`CTR_OFS_GATE_CONTROL, {i[0], i[3:2], i[1], 1'b1});
      span(64, (i[0] == i[1]) ? 8'h40 : 8'h00);
    end
    xfer(1'b1, `CTR_OFS_GATE_CONTROL, 32'h0);
    restart(32'h1);
    sleep <= 1'b1;
    span(64, 8'h00);
    sleep <= 1'b0;
    restart(32'h23);
    chk("osc running", 32'h1, osc_running);
    n = 0;
    repeat (40) begin
      @(posedge pclk);
      n += crystal_out_pin;
    end
    chk("crystal drive", 32'h14, n);
    span(80, 8'h04);
    sleep <= 1'b1;
    span(80, 8'h00);
    sleep <= 1'b0;
    restart(32'h33);
    sleep <= 1'b1;
    span(80, 8'h04);
    sleep <= 1'b0;
    ext_run <= 1'b1;
    restart(32'h3);
    span(80, 8'h08);
    restart(32'h13);
    sleep <= 1'b1;
    span(80, 8'h08);
    sleep <= 1'b0;
    ext_run <= 1'b0;
    xfer(1'b1, `CTR_OFS_CONTROL, 32'h0);
    xfer(1'b1, `CTR_OFS_COUNT_HIGH, 32'hfc);
    xfer(1'b1, `CTR_OFS_COUNT_LOW, 32'h0);
    xfer(1'b1, `CTR_OFS_INT_STATUS, 32'h1);
    xfer(1'b1, `CTR_OFS_INT_MASK, 32'h1);
    xfer(1'b1, `CTR_OFS_CONTROL, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 1200) begin
      @(posedge pclk);
      n++;
    end
    chk("overflow delay", 32'h1, n >= 1020 && n <= 1032);
    rchk(`CTR_OFS_COUNT_HIGH, 32'h0);
    xfer(1'b1, `CTR_OFS_INT_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("masked irq", 32'h0, irq);
    rchk(`CTR_OFS_INT_STATUS, 32'h1);
    xfer(1'b1, `CTR_OFS_INT_MASK, 32'h1);
    xfer(1'b1, `CTR_OFS_INT_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("cleared irq", 32'h0, irq);
    rchk(`CTR_OFS_INT_STATUS, 32'h0);
    end_of_test();
  end
endmodule // gated_counter_tb_top
